// ===== shared/exec_pkg.sv
package exec_pkg;

    // Datapath widths
    localparam int DATA_W = 8;
    localparam int MEM_ADDR_W = 7;
    localparam int BIT_SEL_W = 3;
    localparam int PROG_W = 16;
    localparam int PROG_ADDR_W = 12;
    localparam int PTR_LOW_W = 8;
    localparam int PAGE_W = PROG_ADDR_W - PTR_LOW_W;

    // Field positions inside a program word
    localparam int PROG_LOW_LSB = 0;
    localparam int PROG_HIGH_LSB = 8;

    // Values after reset
    localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
    localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
    localparam logic [PROG_ADDR_W-1:0] PROG_ADDR_RESET = 12'h000;
    localparam logic FLAG_RESET = 1'b0;

    // Constants of the operations
    localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;
    localparam logic [DATA_W-1:0] ONE = 8'h01;
    localparam logic [DATA_W-1:0] ZERO = 8'h00;
    localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hF;

    // Cycle counts: one execute cycle, one dummy cycle on a taken skip
    localparam int EXEC_CYCLES = 1;
    localparam int SKIP_DUMMY_CYCLES = 1;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_DEC_SKIP_MEM = 5'h01,
        OP_DEC_SKIP_WORK = 5'h02,
        OP_INC_SKIP_MEM = 5'h03,
        OP_INC_SKIP_WORK = 5'h04,
        OP_SET_BYTE = 5'h05,
        OP_SET_BIT = 5'h06,
        OP_SKIP_BIT_SET = 5'h07,
        OP_SKIP_BIT_CLEAR = 5'h08,
        OP_SKIP_ZERO = 5'h09,
        OP_MOVE_SKIP_ZERO = 5'h0A,
        OP_SUB_TO_WORK = 5'h0B,
        OP_SUB_TO_MEM = 5'h0C,
        OP_SUB_IMM = 5'h0D,
        OP_SWAP_MEM = 5'h0E,
        OP_SWAP_TO_WORK = 5'h0F,
        OP_TABLE_CURRENT = 5'h10,
        OP_TABLE_LAST = 5'h11,
        OP_XOR_TO_WORK = 5'h12,
        OP_XOR_TO_MEM = 5'h13,
        OP_LOAD_IMM = 5'h14,
        OP_STORE_WORK = 5'h15
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXEC = 2'b11,
        ST_DUMMY = 2'b10
    } state_e;

    typedef struct packed {
        op_e op;
        logic [MEM_ADDR_W-1:0] addr;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic [DATA_W-1:0] imm;
    } cmd_s;

    typedef struct packed {
        logic signed_range;
        logic zero;
        logic nibble_carry;
        logic carry;
    } flags_s;

endpackage

// ===== src/data_ram.sv
`timescale 1ns/100ps
module data_ram
    import exec_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W,
    parameter int WIDTH = DATA_W
) (
    // Clock
    input wire logic clock_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // Read port, data one cycle later
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);

    logic [WIDTH-1:0] mem_q [0:(1<<ADDR_W)-1];

    // No reset on the array so it maps to plain RAM
    always_ff @(posedge clock_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_q[rd_addr_in];
    end

endmodule

// ===== src/sub_alu.sv
`timescale 1ns/100ps
module sub_alu
    import exec_pkg::*;
(
    // Operands
    input wire logic [DATA_W-1:0] minuend_in,
    input wire logic [DATA_W-1:0] subtrahend_in,
    // Result and flags
    output logic [DATA_W-1:0] diff_out,
    output flags_s flags_out
);

    logic [DATA_W:0] wide_diff;
    logic [4:0] low_diff;

    // Borrow taken from the extra top bit of each widened difference
    assign wide_diff = {1'b0, minuend_in} - {1'b0, subtrahend_in};
    assign low_diff = {1'b0, minuend_in[3:0]} - {1'b0, subtrahend_in[3:0]};
    assign diff_out = wide_diff[DATA_W-1:0];

    // Carry is the inverse of borrow, so a negative difference clears it
    assign flags_out.carry = ~wide_diff[DATA_W];
    assign flags_out.nibble_carry = ~low_diff[4];
    assign flags_out.zero = (wide_diff[DATA_W-1:0] == ZERO);
    // Signed overflow: operand signs differ and result sign left the minuend's
    assign flags_out.signed_range = (minuend_in[DATA_W-1] != subtrahend_in[DATA_W-1])
        && (wide_diff[DATA_W-1] != minuend_in[DATA_W-1]);

endmodule

// ===== src/skip_exec_unit.sv
`timescale 1ns/100ps
// Operation
// - A taken skip costs a third, dummy cycle after read and execute; untaken skips finish in two.
// - Decrement-and-skip: byte minus one, to memory or working register.
// - Increment-and-skip: byte plus one, to memory or working register.
// - Set byte writes all ones, no flag changes.
// - Set bit drives only the chosen bit high.
// - Skip when the chosen bit is one.
// - Skip when the chosen bit is zero.
// - Zero test rewrites the byte unchanged, skips when it is zero.
// - Move to working register, skip when the byte is zero.
// - Skip, set, swap and table read leave arithmetic flags alone.
// - Subtract memory from working register into working register, four flags.
// - Carry clear on a negative difference, set otherwise.
// - Subtract with result written back to memory, four flags.
// - Subtract immediate from working register, four flags.
// - Swap nibbles of the byte and write it back.
// - Swap nibbles into working register, memory untouched.
// - Table read at pointer: low byte to memory, high byte to latch.
// - Table read on last page with low pointer, same destinations.
// - Exclusive-or into working register, zero flag only.
// - Exclusive-or into memory, zero flag only.
module skip_exec_unit
    import exec_pkg::*;
#(
    parameter int HAS_HIGH_POINTER = 1
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Command from decode
    input wire logic cmd_valid_in,
    input cmd_s cmd_in,
    output logic cmd_ready_out,
    // Completion
    output logic done_out,
    output logic skip_out,
    // Table pointer from its registers
    input wire logic [PAGE_W-1:0] table_pointer_high_in,
    input wire logic [PTR_LOW_W-1:0] table_pointer_low_in,
    // Program memory read port, one cycle latency
    output logic [PROG_ADDR_W-1:0] prog_addr_out,
    input wire logic [PROG_W-1:0] prog_data_in,
    // Architectural state
    output logic [DATA_W-1:0] working_register_out,
    output logic [DATA_W-1:0] table_high_byte_latch_out,
    output flags_s flags_out,
    // Data memory write observation
    output logic mem_wr_out,
    output logic [MEM_ADDR_W-1:0] mem_wr_addr_out,
    output logic [DATA_W-1:0] mem_wr_data_out
);

    state_e state_q, state_d;
    cmd_s cmd_q;
    logic [DATA_W-1:0] work_q;
    logic [DATA_W-1:0] latch_q;
    flags_s flags_q;
    logic [PROG_ADDR_W-1:0] prog_addr_q;
    logic ready_q, done_q, skip_q;
    logic mem_wr_q;
    logic [MEM_ADDR_W-1:0] mem_wr_addr_q;
    logic [DATA_W-1:0] mem_wr_data_q;

    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] bit_mask;
    logic [DATA_W-1:0] alu_b;
    logic [DATA_W-1:0] alu_diff;
    flags_s alu_flags;

    logic [DATA_W-1:0] result;
    logic wr_mem, wr_work, skip_cond, upd_sub, upd_zero, wr_latch;

    logic accept;
    logic in_exec;
    logic exec_wr;
    logic [DATA_W-1:0] dec_val, inc_val, swap_val, xor_val;
    logic chosen_bit;
    logic [PAGE_W-1:0] page_sel;
    logic [PROG_ADDR_W-1:0] table_addr;
    logic [MEM_ADDR_W-1:0] ram_wr_addr;
    logic [DATA_W-1:0] ram_wr_data;
    logic [MEM_ADDR_W-1:0] ram_rd_addr;

    // One-hot mask of the selected bit position
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_mask
            assign bit_mask[gi] = (cmd_q.bit_sel == BIT_SEL_W'(gi));
        end
    endgenerate

    // Handshake and phase decode
    assign accept = ready_q && cmd_valid_in;
    assign in_exec = (state_q == ST_EXEC);

    // Candidate results from the byte just read
    assign dec_val = rd_data - ONE;
    assign inc_val = rd_data + ONE;
    assign swap_val = {rd_data[3:0], rd_data[7:4]};
    assign xor_val = work_q ^ rd_data;
    assign chosen_bit = |(rd_data & bit_mask);

    // Immediate form takes the constant instead of the memory byte
    assign alu_b = (cmd_q.op == OP_SUB_IMM) ? cmd_q.imm : rd_data;

    // Table address: last page forces the page bits, else pointer high if present
    assign page_sel = (cmd_in.op == OP_TABLE_LAST) ? LAST_PAGE :
        ((HAS_HIGH_POINTER != 0) ? table_pointer_high_in : {PAGE_W{1'b0}});
    assign table_addr = {page_sel, table_pointer_low_in};

    // Read address comes from the incoming command so data lands for exec
    assign ram_rd_addr = accept ? cmd_in.addr : cmd_q.addr;

    sub_alu u_alu (
        .minuend_in(work_q),
        .subtrahend_in(alu_b),
        .diff_out(alu_diff),
        .flags_out(alu_flags)
    );

    // Per-operation effects, evaluated during the execute cycle
    always_comb begin
        result = rd_data;
        wr_mem = 1'b0;
        wr_work = 1'b0;
        skip_cond = 1'b0;
        upd_sub = 1'b0;
        upd_zero = 1'b0;
        wr_latch = 1'b0;
        unique case (cmd_q.op)
            OP_DEC_SKIP_MEM: begin
                result = dec_val;
                wr_mem = 1'b1;
                skip_cond = (dec_val == ZERO);
            end
            OP_DEC_SKIP_WORK: begin
                result = dec_val;
                wr_work = 1'b1;
                skip_cond = (dec_val == ZERO);
            end
            OP_INC_SKIP_MEM: begin
                result = inc_val;
                wr_mem = 1'b1;
                skip_cond = (inc_val == ZERO);
            end
            OP_INC_SKIP_WORK: begin
                result = inc_val;
                wr_work = 1'b1;
                skip_cond = (inc_val == ZERO);
            end
            OP_SET_BYTE: begin
                result = ALL_ONES;
                wr_mem = 1'b1;
            end
            OP_SET_BIT: begin
                result = rd_data | bit_mask;
                wr_mem = 1'b1;
            end
            OP_SKIP_BIT_SET: begin
                skip_cond = chosen_bit;
            end
            OP_SKIP_BIT_CLEAR: begin
                skip_cond = !chosen_bit;
            end
            OP_SKIP_ZERO: begin
                result = rd_data;
                wr_mem = 1'b1;
                skip_cond = (rd_data == ZERO);
            end
            OP_MOVE_SKIP_ZERO: begin
                result = rd_data;
                wr_work = 1'b1;
                skip_cond = (rd_data == ZERO);
            end
            OP_SUB_TO_WORK, OP_SUB_IMM: begin
                result = alu_diff;
                wr_work = 1'b1;
                upd_sub = 1'b1;
            end
            OP_SUB_TO_MEM: begin
                result = alu_diff;
                wr_mem = 1'b1;
                upd_sub = 1'b1;
            end
            OP_SWAP_MEM: begin
                result = swap_val;
                wr_mem = 1'b1;
            end
            OP_SWAP_TO_WORK: begin
                result = swap_val;
                wr_work = 1'b1;
            end
            OP_TABLE_CURRENT, OP_TABLE_LAST: begin
                result = prog_data_in[PROG_LOW_LSB +: DATA_W];
                wr_mem = 1'b1;
                wr_latch = 1'b1;
            end
            OP_XOR_TO_WORK: begin
                result = xor_val;
                wr_work = 1'b1;
                upd_zero = 1'b1;
            end
            OP_XOR_TO_MEM: begin
                result = xor_val;
                wr_mem = 1'b1;
                upd_zero = 1'b1;
            end
            OP_LOAD_IMM: begin
                result = cmd_q.imm;
                wr_work = 1'b1;
            end
            OP_STORE_WORK: begin
                result = work_q;
                wr_mem = 1'b1;
            end
            default: begin
                result = rd_data;
            end
        endcase
    end

    // Memory write happens only in the execute cycle
    assign exec_wr = in_exec && wr_mem;
    assign ram_wr_addr = cmd_q.addr;
    assign ram_wr_data = result;

    data_ram #(
        .ADDR_W(MEM_ADDR_W),
        .WIDTH(DATA_W)
    ) u_ram (
        .clock_in(clock_in),
        .wr_en_in(exec_wr),
        .wr_addr_in(ram_wr_addr),
        .wr_data_in(ram_wr_data),
        .rd_addr_in(ram_rd_addr),
        .rd_data_out(rd_data)
    );

    // Sequencer: read, execute, then a dummy slot only for a taken skip
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                state_d = ST_EXEC;
            end
            ST_EXEC: begin
                state_d = skip_cond ? ST_DUMMY : ST_IDLE;
            end
            ST_DUMMY: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State and handshake registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == ST_IDLE);
            done_q <= (in_exec && !skip_cond) || (state_q == ST_DUMMY);
            skip_q <= in_exec && skip_cond;
        end
    end

    // Command capture; table address is issued a cycle ahead of execute
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_q <= '0;
            prog_addr_q <= PROG_ADDR_RESET;
        end else if (accept) begin
            cmd_q <= cmd_in;
            prog_addr_q <= table_addr;
        end
    end

    // Working register and table latch
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            work_q <= WORK_RESET;
            latch_q <= LATCH_RESET;
        end else if (in_exec) begin
            if (wr_work) begin
                work_q <= result;
            end
            if (wr_latch) begin
                latch_q <= prog_data_in[PROG_HIGH_LSB +: DATA_W];
            end
        end
    end

    // Flags move only for subtract and exclusive-or; others keep them
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flags_q <= '{FLAG_RESET, FLAG_RESET, FLAG_RESET, FLAG_RESET};
        end else if (in_exec && upd_sub) begin
            flags_q <= alu_flags;
        end else if (in_exec && upd_zero) begin
            flags_q.zero <= (result == ZERO);
        end
    end

    // Mirror of the memory write, for whoever watches data memory
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mem_wr_q <= 1'b0;
            mem_wr_addr_q <= '0;
            mem_wr_data_q <= ZERO;
        end else begin
            mem_wr_q <= exec_wr;
            if (exec_wr) begin
                mem_wr_addr_q <= ram_wr_addr;
                mem_wr_data_q <= ram_wr_data;
            end
        end
    end

    // All outputs straight from flip-flops
    assign cmd_ready_out = ready_q;
    assign done_out = done_q;
    assign skip_out = skip_q;
    assign prog_addr_out = prog_addr_q;
    assign working_register_out = work_q;
    assign table_high_byte_latch_out = latch_q;
    assign flags_out = flags_q;
    assign mem_wr_out = mem_wr_q;
    assign mem_wr_addr_out = mem_wr_addr_q;
    assign mem_wr_data_out = mem_wr_data_q;

endmodule

// ===== bench/skip_exec_monitor.sv
`timescale 1ns/100ps
module skip_exec_monitor
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Command handshake
    input wire logic cmd_valid_in,
    input cmd_s cmd_in,
    input wire logic cmd_ready_out,
    input wire logic done_out,
    input wire logic skip_out,
    // Table pointer and program memory
    input wire logic [PAGE_W-1:0] table_pointer_high_in,
    input wire logic [PTR_LOW_W-1:0] table_pointer_low_in,
    input wire logic [PROG_ADDR_W-1:0] prog_addr_out,
    input wire logic [PROG_W-1:0] prog_data_in,
    // State and memory writes
    input wire logic [DATA_W-1:0] working_register_out,
    input wire logic [DATA_W-1:0] table_high_byte_latch_out,
    input flags_s flags_out,
    input wire logic mem_wr_out,
    input wire logic [MEM_ADDR_W-1:0] mem_wr_addr_out,
    input wire logic [DATA_W-1:0] mem_wr_data_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // Accepted command, and whether it may touch the flags
    wire take = cmd_valid_in && cmd_ready_out;
    wire arith = cmd_in.op inside {OP_SUB_TO_WORK, OP_SUB_TO_MEM, OP_SUB_IMM,
        OP_XOR_TO_WORK, OP_XOR_TO_MEM};

    // Program word as the execute cycle sampled it
    logic [PROG_W-1:0] prog_q;
    always_ff @(posedge clock_in) begin
        prog_q <= prog_data_in;
    end

    sequence s_take(op_e o);
        take && cmd_in.op == o;
    endsequence

    a_done_timing: assert property (take |-> ##3 (done_out ^ skip_out))
        else $error("done or skip not three cycles after accept");
    a_skip_then_done: assert property (skip_out |=> done_out && cmd_ready_out)
        else $error("dummy cycle not followed by done");
    a_busy_refuses: assert property (take |=> (!cmd_ready_out && !done_out) [*2])
        else $error("ready or done during execution");
    a_set_byte_ones: assert property (s_take(OP_SET_BYTE) |-> ##3
        mem_wr_out && mem_wr_data_out == ALL_ONES && $stable(flags_out))
        else $error("set byte wrote wrong value");
    a_flags_kept: assert property (take && !arith |=> $stable(flags_out) [*3])
        else $error("flags changed by flag neutral op");
    a_sub_zero_work: assert property ((s_take(OP_SUB_TO_WORK) or s_take(OP_SUB_IMM))
        |-> ##3 flags_out.zero == (working_register_out == ZERO))
        else $error("subtract zero flag wrong");
    a_sub_zero_mem: assert property (s_take(OP_SUB_TO_MEM) |-> ##3
        mem_wr_out && flags_out.zero == (mem_wr_data_out == ZERO))
        else $error("subtract to memory zero flag wrong");
    a_xor_zero_only: assert property (s_take(OP_XOR_TO_WORK) |-> ##3
        flags_out.zero == (working_register_out == ZERO) && $stable(flags_out.carry)
        && $stable(flags_out.nibble_carry) && $stable(flags_out.signed_range))
        else $error("exclusive or flags wrong");
    a_table_last: assert property (s_take(OP_TABLE_LAST) |=>
        prog_addr_out == {LAST_PAGE, $past(table_pointer_low_in)} ##2
        (table_high_byte_latch_out == prog_q[15:8] && mem_wr_data_out == prog_q[7:0]))
        else $error("last page table read wrong");
endmodule

bind skip_exec_unit skip_exec_monitor mon_u (.clock_in(clock_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
    .done_out(done_out), .skip_out(skip_out), .table_pointer_high_in(table_pointer_high_in),
    .table_pointer_low_in(table_pointer_low_in), .prog_addr_out(prog_addr_out),
    .prog_data_in(prog_data_in), .working_register_out(working_register_out),
    .table_high_byte_latch_out(table_high_byte_latch_out), .flags_out(flags_out),
    .mem_wr_out(mem_wr_out), .mem_wr_addr_out(mem_wr_addr_out),
    .mem_wr_data_out(mem_wr_data_out));

// ===== bench/testbench.sv
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("Error at %0t: value %h, expected %h", $time, a, e); end end
module testbench;
    import exec_pkg::*;
    // One row per command: op a b imm work skip wr data latch flags
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] a;
        logic [3:0] b;
        logic [7:0] i;
        logic [7:0] w;
        logic [3:0] s;
        logic [3:0] m;
        logic [7:0] d;
        logic [7:0] l;
        logic [3:0] f;
    } row_s;
    logic [63:0] rows [36] = '{
        64'h14_00_0_05_05_0_0_00_00_0, 64'h15_10_0_00_05_0_1_05_00_0,
        64'h01_10_0_00_05_0_1_04_00_0, 64'h14_00_0_01_01_0_0_00_00_0,
        64'h15_11_0_00_01_0_1_01_00_0, 64'h01_11_0_00_01_1_1_00_00_0,
        64'h02_10_0_00_03_0_0_00_00_0, 64'h02_11_0_00_FF_0_0_00_00_0,
        64'h03_11_0_00_FF_0_1_01_00_0, 64'h02_11_0_00_00_1_0_00_00_0,
        64'h05_12_0_00_00_0_1_FF_00_0, 64'h04_12_0_00_00_1_0_00_00_0,
        64'h04_11_0_00_02_0_0_00_00_0, 64'h03_12_0_00_02_1_1_00_00_0,
        64'h09_12_0_00_02_1_1_00_00_0, 64'h09_11_0_00_02_0_1_01_00_0,
        64'h0A_12_0_00_00_1_0_00_00_0, 64'h06_12_7_00_00_0_1_80_00_0,
        64'h06_12_0_00_00_0_1_81_00_0, 64'h07_12_7_00_00_1_0_00_00_0,
        64'h07_12_1_00_00_0_0_00_00_0, 64'h08_12_1_00_00_1_0_00_00_0,
        64'h08_12_0_00_00_0_0_00_00_0, 64'h0A_11_0_00_01_0_0_00_00_0,
        64'h0B_10_0_00_FD_0_0_00_00_0, 64'h0C_10_0_00_FD_0_1_F9_00_3,
        64'h0D_00_0_7F_7E_0_0_00_00_9, 64'h0D_00_0_7E_00_0_0_00_00_7,
        64'h0E_12_0_00_00_0_1_18_00_7, 64'h0F_10_0_00_9F_0_0_00_00_7,
        64'h10_13_0_5A_9F_0_1_5A_C3_7, 64'h11_14_0_A7_9F_0_1_A7_CF_7,
        64'h12_13_0_00_C5_0_0_00_CF_3, 64'h14_00_0_A7_A7_0_0_00_CF_3,
        64'h13_14_0_00_A7_0_1_00_CF_7, 64'h00_00_0_00_A7_0_0_00_CF_7};

    // Design ports
    logic clock_in;
    logic rst_in;
    logic cmd_valid_in;
    cmd_s cmd_in;
    logic [PAGE_W-1:0] table_pointer_high_in;
    logic [PTR_LOW_W-1:0] table_pointer_low_in;
    logic [PROG_W-1:0] prog_data_in = '0;
    logic cmd_ready_out, done_out, skip_out, mem_wr_out;
    logic [PROG_ADDR_W-1:0] prog_addr_out;
    logic [DATA_W-1:0] working_register_out, table_high_byte_latch_out, mem_wr_data_out;
    flags_s flags_out;
    logic [MEM_ADDR_W-1:0] mem_wr_addr_out;
    int num_errors = 0;
    int num_checks = 0;

    skip_exec_unit dut_u (.clock_in(clock_in), .rst_in(rst_in),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
        .done_out(done_out), .skip_out(skip_out), .table_pointer_high_in(table_pointer_high_in),
        .table_pointer_low_in(table_pointer_low_in), .prog_addr_out(prog_addr_out),
        .prog_data_in(prog_data_in), .working_register_out(working_register_out),
        .table_high_byte_latch_out(table_high_byte_latch_out), .flags_out(flags_out),
        .mem_wr_out(mem_wr_out), .mem_wr_addr_out(mem_wr_addr_out),
        .mem_wr_data_out(mem_wr_data_out));

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    // Sync program memory; the page marker makes the high byte show the page
    always @(posedge clock_in) begin
        prog_data_in <= {4'hC, prog_addr_out};
    end

    task automatic tally_and_finish;
        $display("Checks made: %0d, errors: %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Offer one command, watch it through to done
    task automatic run_row(input row_s r);
        int n;
        logic sk;
        logic wr;
        @(posedge clock_in);
        cmd_valid_in <= 1'b1;
        cmd_in <= '{op_e'(r.op[4:0]), r.a[6:0], r.b[2:0], r.i};
        table_pointer_low_in <= r.i;
        @(posedge clock_in);
        cmd_valid_in <= 1'b0;
        n = 0;
        sk = 1'b0;
        wr = 1'b0;
        do begin
            @(posedge clock_in);
            #1;
            n++;
            if (skip_out === 1'b1) sk = 1'b1;
            if (mem_wr_out === 1'b1) wr = 1'b1;
        end while (done_out !== 1'b1 && n < 8);
        // Done shows two edges after the taking edge, three with the dummy slot
        `CHK(n, (r.s[0] ? 3 : 2))
        `CHK(sk, r.s[0])
        `CHK(wr, r.m[0])
        if (r.m[0]) `CHK(mem_wr_data_out, r.d)
        if (r.m[0]) `CHK(mem_wr_addr_out, r.a[6:0])
        `CHK(working_register_out, r.w)
        `CHK(table_high_byte_latch_out, r.l)
        `CHK(flags_out, r.f)
    endtask

    // Watchdog, well past the expected run of some 180 cycles
    initial begin
        repeat (3000) @(posedge clock_in);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        rst_in = 1'b1;
        cmd_valid_in = 1'b0;
        cmd_in = '0;
        table_pointer_high_in = 4'h3;
        table_pointer_low_in = 8'h00;
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        for (int k = 0; k < 36; k++) begin
            run_row(rows[k]);
        end
        // Reset in mid-instruction must abort it cleanly
        @(posedge clock_in);
        cmd_valid_in <= 1'b1;
        cmd_in <= '{OP_SET_BYTE, 7'h20, 3'h0, 8'h00};
        @(posedge clock_in);
        cmd_valid_in <= 1'b0;
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        `CHK(done_out, 1'b0)
        `CHK(mem_wr_out, 1'b0)
        `CHK(table_high_byte_latch_out, 8'h00)
        @(posedge clock_in);
        rst_in <= 1'b0;
        run_row(64'h14_00_0_3C_3C_0_0_00_00_0);
        // Current page must follow a new pointer high, not stay on the old one
        @(posedge clock_in);
        table_pointer_high_in <= 4'h6;
        run_row(64'h10_15_0_21_3C_0_1_21_C6_0);
        `CHK(prog_addr_out, 12'h621)
        tally_and_finish();
    end
endmodule
